// [hw/dpag_defs.vh]
/*
 * Constants for the data page address generator: page select decode
 * boundaries, reset values and addressing mode codes.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef DPAG_DEFS_VH
`define DPAG_DEFS_VH

// Widths
`define DPAG_PAGE_W 10
`define DPAG_ADDR_W 16
// Window bit of the effective address
`define DPAG_EA_WIN_BIT 15
// Page select decode boundaries
`define DPAG_PG_ZERO 10'h000
`define DPAG_PG_EDS_FIRST 10'h001
`define DPAG_PG_EDS_LAST 10'h1FF
`define DPAG_PG_PSV_FIRST 10'h200
`define DPAG_PG_PSV_LSW_LAST 10'h2FF
`define DPAG_PG_PSV_MSW_FIRST 10'h300
`define DPAG_PG_PSV_LAST 10'h3FF
// Reset values of the page selects
`define DPAG_RD_PAGE_RST 10'h001
`define DPAG_WR_PAGE_RST 10'h001
// Addressing modes
`define DPAG_MODE_DIRECT 3'h0
`define DPAG_MODE_PREMOD 3'h1
`define DPAG_MODE_POSTMOD 3'h2
`define DPAG_MODE_REGOFS 3'h3
`define DPAG_MODE_MODULO 3'h4
`define DPAG_MODE_BITREV 3'h5
// Bit-reversed buffer index width (16 entries)
`define DPAG_BITREV_W 4

`endif

// [hw/dpag_page_step.v]
/*
 * One page-select stepping unit: given a page select, the unmodified and
 * modified effective address, mode and carry direction, it gives the
 * corrected page and effective address. Pure combinational.
 * Assumes the caller decides read or write side and registers results.
 */
`timescale 1ns/1ps
`include "dpag_defs.vh"

module dpag_page_step (
    input wire [9:0] PAGE_IN,
    input wire [2:0] MODE,
    input wire [15:0] EA_BASE,
    input wire [15:0] EA_CALC,
    input wire OVF,
    input wire UNF,
    output reg [9:0] PAGE_OUT,
    output reg [15:0] EA_OUT,
    output reg CARRIED
);

    ////////////////////////////////////////////////////////////////////////
    // Paged-window detection
    wire base_paged;
    wire linear_mode;
    wire [15:0] ea_cleared;

    // Only window accesses with pre/post modify carry pages
    assign base_paged = EA_BASE[`DPAG_EA_WIN_BIT] && (PAGE_IN != `DPAG_PG_ZERO);
    assign linear_mode = (MODE == `DPAG_MODE_PREMOD) || (MODE == `DPAG_MODE_POSTMOD);
    // Bit 15 cleared by the calculation before correction
    assign ea_cleared = {1'b0, EA_CALC[14:0]};

    ////////////////////////////////////////////////////////////////////////
    // Page correction
    always @* begin
        PAGE_OUT = PAGE_IN;
        EA_OUT = EA_CALC;
        CARRIED = 1'b0;
        if (base_paged && (OVF || UNF)) begin
            EA_OUT = ea_cleared;
            if (!linear_mode) begin
                // Wrap within current page: low 15 bits kept, bit 15 set again
                EA_OUT = {1'b1, EA_CALC[14:0]};
            end else if (OVF) begin
                if (PAGE_IN == `DPAG_PG_EDS_LAST || PAGE_IN == `DPAG_PG_PSV_LAST) begin
                    EA_OUT = ea_cleared;
                end else begin
                    // Includes 0x2FF to 0x300 with bit 15 kept
                    PAGE_OUT = PAGE_IN + 10'h001;
                    EA_OUT = {1'b1, EA_CALC[14:0]};
                    CARRIED = 1'b1;
                end
            end else begin
                if (PAGE_IN == `DPAG_PG_EDS_FIRST || PAGE_IN == `DPAG_PG_PSV_FIRST) begin
                    EA_OUT = ea_cleared;
                end else begin
                    // Includes 0x300 to 0x2FF with bit 15 kept
                    PAGE_OUT = PAGE_IN - 10'h001;
                    EA_OUT = {1'b1, EA_CALC[14:0]};
                    CARRIED = 1'b1;
                end
            end
        end
    end

endmodule // dpag_page_step

// [hw/dpag_top.v]
/*
 * Data page address generator: keeps read and write page selects,
 * forms effective addresses for each addressing mode, carries pages
 * across boundaries and raises address error traps.
 * Assumes the core presents one access per cycle with a valid strobe
 * on the same clock; results appear one cycle later.
 * A page load from the core in the same cycle as a carry wins.
 * Only one window crossing per step is carried; large offsets are
 * left to software.
 */
`timescale 1ns/1ps
`include "dpag_defs.vh"

// How it works
// - Separate read and write page select registers
// - One move reads one page, writes another
// - Overflow/underflow clears effective address bit 15
// - Detect only for window accesses in modes other than direct
// - Overflow increments page, sets bit 15
// - Underflow decrements page, sets bit 15
// - Linear carrying only in pre/post modify
// - Offset, modulo, bit-reverse wrap within page
// - Boundary pages fall to base data space
// - Program window halves carry keeping bit 15
// - Extended access with page zero traps
// - Program space writes trap
// - Large offsets need not carry linearly
// - Bit-reversed index mirrors low four bits
module dpag_top (
    input wire CLOCK,
    input wire RST_B,
    input wire RD_PAGE_WE,
    input wire [9:0] RD_PAGE_WDATA,
    input wire WR_PAGE_WE,
    input wire [9:0] WR_PAGE_WDATA,
    input wire RD_VALID,
    input wire [2:0] RD_MODE,
    input wire [15:0] RD_BASE,
    input wire [15:0] RD_OFFSET,
    input wire WR_VALID,
    input wire [2:0] WR_MODE,
    input wire [15:0] WR_BASE,
    input wire [15:0] WR_OFFSET,
    output wire [9:0] RD_PAGE,
    output wire [9:0] WR_PAGE,
    output reg [15:0] RD_ADDR,
    output reg [9:0] RD_ADDR_PAGE,
    output reg RD_ADDR_VALID,
    output reg [15:0] WR_ADDR,
    output reg [9:0] WR_ADDR_PAGE,
    output reg WR_ADDR_VALID,
    output reg ADDR_ERR_TRAP
);

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers
    function is_eds;
        input [9:0] pg;
        begin
            is_eds = (pg >= `DPAG_PG_EDS_FIRST) && (pg <= `DPAG_PG_EDS_LAST);
        end
    endfunction

    function is_psv;
        input [9:0] pg;
        begin
            is_psv = (pg >= `DPAG_PG_PSV_FIRST);
        end
    endfunction

    // Address calculation per mode; bit 16 flags a carry out of the window
    function [16:0] calc_ea;
        input [2:0] mode;
        input [15:0] base;
        input [15:0] ofs;
        reg [16:0] sum;
        begin
            sum = {1'b0, base} + {ofs[15], ofs};
            calc_ea = sum;
            // Post-modify and direct use the unmodified address
            if (mode == `DPAG_MODE_POSTMOD || mode == `DPAG_MODE_DIRECT) begin
                calc_ea = {1'b0, base};
            end else if (mode == `DPAG_MODE_BITREV) begin
                // Mirror of the 16-entry index
                calc_ea = {1'b0, base[15:4], base[0], base[1], base[2], base[3]};
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Page select registers, independent for read and write
    reg [9:0] rd_page_q;
    reg [9:0] rd_page_d;
    reg [9:0] wr_page_q;
    reg [9:0] wr_page_d;

    assign RD_PAGE = rd_page_q;
    assign WR_PAGE = wr_page_q;

    ////////////////////////////////////////////////////////////////////////
    // Overflow/underflow detection within the window
    wire [16:0] rd_sum;
    wire [16:0] wr_sum;
    wire [16:0] rd_next;
    wire [16:0] wr_next;
    wire rd_ovf;
    wire rd_unf;
    wire wr_ovf;
    wire wr_unf;

    assign rd_sum = calc_ea(RD_MODE, RD_BASE, RD_OFFSET);
    assign wr_sum = calc_ea(WR_MODE, WR_BASE, WR_OFFSET);
    // Post-modify updates the register value; its next value decides the carry
    assign rd_next = {1'b0, RD_BASE} + {RD_OFFSET[15], RD_OFFSET};
    assign wr_next = {1'b0, WR_BASE} + {WR_OFFSET[15], WR_OFFSET};
    // Leaving the upper half means a page boundary was crossed.
    // Only the window bit and the carry out are watched, so an offset that jumps
    // past a whole page is not carried linearly
    assign rd_ovf = (RD_MODE != `DPAG_MODE_DIRECT) && RD_BASE[15] && !RD_OFFSET[15]
        && (rd_next[16] || !rd_next[15]);
    assign rd_unf = (RD_MODE != `DPAG_MODE_DIRECT) && RD_BASE[15] && RD_OFFSET[15]
        && !rd_next[15];
    assign wr_ovf = (WR_MODE != `DPAG_MODE_DIRECT) && WR_BASE[15] && !WR_OFFSET[15]
        && (wr_next[16] || !wr_next[15]);
    assign wr_unf = (WR_MODE != `DPAG_MODE_DIRECT) && WR_BASE[15] && WR_OFFSET[15]
        && !wr_next[15];

    ////////////////////////////////////////////////////////////////////////
    // Page stepping units, one per direction
    wire [9:0] rd_step_page;
    wire [15:0] rd_step_ea;
    wire rd_carried;
    wire [9:0] wr_step_page;
    wire [15:0] wr_step_ea;
    wire wr_carried;

    // Read side stepping unit
    dpag_page_step u_rd_step (
        .PAGE_IN(rd_page_q),
        .MODE(RD_MODE),
        .EA_BASE(RD_BASE),
        .EA_CALC(rd_sum[15:0]),
        .OVF(rd_ovf),
        .UNF(rd_unf),
        .PAGE_OUT(rd_step_page),
        .EA_OUT(rd_step_ea),
        .CARRIED(rd_carried)
    );

    // Write side stepping unit
    dpag_page_step u_wr_step (
        .PAGE_IN(wr_page_q),
        .MODE(WR_MODE),
        .EA_BASE(WR_BASE),
        .EA_CALC(wr_sum[15:0]),
        .OVF(wr_ovf),
        .UNF(wr_unf),
        .PAGE_OUT(wr_step_page),
        .EA_OUT(wr_step_ea),
        .CARRIED(wr_carried)
    );

    ////////////////////////////////////////////////////////////////////////
    // Trap detection
    wire rd_trap;
    wire wr_trap;

    // Window access with page zero is illegal
    assign rd_trap = RD_VALID && RD_BASE[15]
        && !is_eds(rd_page_q) && !is_psv(rd_page_q);
    // Write page pointing into program space, or page zero
    assign wr_trap = WR_VALID && WR_BASE[15]
        && (is_psv(wr_page_q) || (wr_page_q == `DPAG_PG_ZERO));

    ////////////////////////////////////////////////////////////////////////
    // Next page selects: core load wins over a hardware carry
    always @* begin
        rd_page_d = rd_page_q;
        wr_page_d = wr_page_q;
        if (RD_VALID && !rd_trap && rd_carried) begin
            rd_page_d = rd_step_page;
        end
        if (WR_VALID && !wr_trap && wr_carried) begin
            wr_page_d = wr_step_page;
        end
        // A core load overrides any carry in the same cycle
        if (RD_PAGE_WE) begin
            rd_page_d = RD_PAGE_WDATA;
        end
        if (WR_PAGE_WE) begin
            wr_page_d = WR_PAGE_WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Page registers and registered address outputs
    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rd_page_q <= `DPAG_RD_PAGE_RST;
            wr_page_q <= `DPAG_WR_PAGE_RST;
            RD_ADDR <= 16'h0000;
            RD_ADDR_PAGE <= 10'h000;
            RD_ADDR_VALID <= 1'b0;
            WR_ADDR <= 16'h0000;
            WR_ADDR_PAGE <= 10'h000;
            WR_ADDR_VALID <= 1'b0;
            ADDR_ERR_TRAP <= 1'b0;
        end else begin
            rd_page_q <= rd_page_d;
            wr_page_q <= wr_page_d;
            // Read and write sides issue in the same cycle for a move
            RD_ADDR_VALID <= RD_VALID && !rd_trap;
            WR_ADDR_VALID <= WR_VALID && !wr_trap;
            RD_ADDR <= rd_step_ea;
            WR_ADDR <= wr_step_ea;
            // Page used by this access: post-modify uses old page
            RD_ADDR_PAGE <= (RD_MODE == `DPAG_MODE_POSTMOD) ? rd_page_q : rd_step_page;
            WR_ADDR_PAGE <= (WR_MODE == `DPAG_MODE_POSTMOD) ? wr_page_q : wr_step_page;
            // Trap pulse replaces the answer for one cycle
            ADDR_ERR_TRAP <= rd_trap || wr_trap;
        end
    end

endmodule // dpag_top

// [verification/dpag_asserts.sv]
/* Port checker for dpag_top: answers, traps and page carrying.
   Assumes a bind onto dpag_top, one clock, RST_B asynchronous low. */
`timescale 1ns/1ps
module dpag_asserts (
    input wire CLOCK,
    input wire RST_B,
    input wire RD_PAGE_WE,
    input wire WR_PAGE_WE,
    input wire RD_VALID,
    input wire [2:0] RD_MODE,
    input wire [15:0] RD_BASE,
    input wire [15:0] RD_OFFSET,
    input wire WR_VALID,
    input wire [15:0] WR_BASE,
    input wire [9:0] RD_PAGE,
    input wire [9:0] WR_PAGE,
    input wire [15:0] RD_ADDR,
    input wire RD_ADDR_VALID,
    input wire WR_ADDR_VALID,
    input wire ADDR_ERR_TRAP
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    // Small pre-modify steps leaving the window upward or downward
    wire [15:0] sum = RD_BASE + RD_OFFSET;
    wire win = RD_VALID && !RD_PAGE_WE && RD_BASE[15] && RD_MODE == 3'h1;
    wire up = win && !RD_OFFSET[15] && RD_OFFSET < 16'h0100 && !sum[15];
    wire dn = win && RD_OFFSET > 16'hFF00 && !sum[15];
    wire edge_pg = up && (RD_PAGE == 10'h1FF || RD_PAGE == 10'h3FF) ||
        dn && (RD_PAGE == 10'h001 || RD_PAGE == 10'h200);
    wire fix_md = RD_VALID && !RD_PAGE_WE && (RD_MODE == 3'h0 || RD_MODE >= 3'h3);
    sequence s_up;
        up && RD_PAGE != 10'h000 && RD_PAGE != 10'h1FF && RD_PAGE != 10'h3FF;
    endsequence
    sequence s_dn;
        dn && RD_PAGE != 10'h000 && RD_PAGE != 10'h001 && RD_PAGE != 10'h200;
    endsequence
    sequence s_inc;
        RD_ADDR[15] && RD_PAGE == $past(RD_PAGE) + 10'h001;
    endsequence
    sequence s_dec;
        RD_ADDR[15] && RD_PAGE == $past(RD_PAGE) - 10'h001;
    endsequence
    AST_OVF_CARRY: assert property (s_up |=> s_inc)
        else $error("overflow did not advance page");
    AST_UNF_CARRY: assert property (s_dn |=> s_dec)
        else $error("underflow did not step page back");
    AST_EDGE_PAGE: assert property (edge_pg |=> $stable(RD_PAGE) && !RD_ADDR[15])
        else $error("boundary page carried");
    AST_NO_CARRY: assert property (fix_md |=> $stable(RD_PAGE))
        else $error("wrapping mode changed page");
    AST_RD_HOLD: assert property (!RD_PAGE_WE && !RD_VALID |=> $stable(RD_PAGE))
        else $error("read page moved when idle");
    AST_WR_HOLD: assert property (!WR_PAGE_WE && !WR_VALID |=> $stable(WR_PAGE))
        else $error("write page moved when idle");
    AST_RD_ANSWER: assert property (RD_ADDR_VALID |-> $past(RD_VALID))
        else $error("read answer without request");
    AST_PAGE0_TRAP: assert property (
        RD_VALID && !RD_PAGE_WE && RD_BASE[15] && RD_PAGE == 10'h000
        |=> ADDR_ERR_TRAP && !RD_ADDR_VALID) else $error("page zero did not trap");
    AST_PS_TRAP: assert property (
        WR_VALID && !WR_PAGE_WE && WR_BASE[15] && WR_PAGE >= 10'h200
        |=> ADDR_ERR_TRAP && !WR_ADDR_VALID) else $error("program write did not trap");
endmodule // dpag_asserts
bind dpag_top dpag_asserts dpag_asserts_inst (.CLOCK(CLOCK), .RST_B(RST_B),
    .RD_PAGE_WE(RD_PAGE_WE), .WR_PAGE_WE(WR_PAGE_WE), .RD_VALID(RD_VALID),
    .RD_MODE(RD_MODE), .RD_BASE(RD_BASE), .RD_OFFSET(RD_OFFSET), .WR_VALID(WR_VALID),
    .WR_BASE(WR_BASE), .RD_PAGE(RD_PAGE), .WR_PAGE(WR_PAGE), .RD_ADDR(RD_ADDR),
    .RD_ADDR_VALID(RD_ADDR_VALID), .WR_ADDR_VALID(WR_ADDR_VALID),
    .ADDR_ERR_TRAP(ADDR_ERR_TRAP));

// [verification/dpag_mem_model.sv]
/* Data memory partner: words by page and address; a read and a write
   answered together form a move. Assumes answers last one cycle. */
`timescale 1ns/1ps
module dpag_mem_model (
    input wire clock,
    input wire rd_ok,
    input wire [9:0] rd_pg,
    input wire [15:0] rd_ea,
    input wire wr_ok,
    input wire [9:0] wr_pg,
    input wire [15:0] wr_ea,
    input wire [15:0] wr_data,
    output reg [15:0] rd_data
);
    // Small store: low page and word bits pick a word, so far pages alias
    reg [15:0] mem [0:255];
    wire [7:0] rd_ix = {rd_pg[4:0], rd_ea[3:1]};
    wire [7:0] wr_ix = {wr_pg[4:0], wr_ea[3:1]};
    initial rd_data = 16'h0000;
    // Move, store and read; idle read data toggles
    always @(posedge clock) begin
        if (rd_ok && wr_ok)
            mem[wr_ix] <= mem[rd_ix];
        else if (wr_ok)
            mem[wr_ix] <= wr_data;
        rd_data <= rd_ok ? mem[rd_ix] : ~rd_data;
    end
endmodule // dpag_mem_model

// [verification/dpag_top_tb_top.sv]
/* Testbench for dpag_top with the data memory partner.
   Assumes dpag_defs.vh on the include path. */
`timescale 1ns/1ps
`include "dpag_defs.vh"
module dpag_top_tb_top;
    reg clock = 1'b0, rst_b = 1'b0, rd_we = 1'b0, wr_we = 1'b0, rd_v = 1'b0, wr_v = 1'b0;
    reg [9:0] rd_wd = 10'h000, wr_wd = 10'h000;
    reg [2:0] md = 3'h0;
    reg [15:0] bs = 16'h0000, ofs = 16'h0000, m_wd = 16'h0000;
    wire [9:0] rd_pg, wr_pg, rd_apg, wr_apg;
    wire [15:0] rd_ea, wr_ea, m_rd;
    wire rd_ok, wr_ok, trap;
    integer n_errors = 0, checks = 0, i;
    dpag_top dpag_top_inst (.CLOCK(clock), .RST_B(rst_b), .RD_PAGE_WE(rd_we),
        .RD_PAGE_WDATA(rd_wd), .WR_PAGE_WE(wr_we), .WR_PAGE_WDATA(wr_wd), .RD_VALID(rd_v),
        .RD_MODE(md), .RD_BASE(bs), .RD_OFFSET(ofs), .WR_VALID(wr_v), .WR_MODE(md),
        .WR_BASE(bs), .WR_OFFSET(ofs), .RD_PAGE(rd_pg), .WR_PAGE(wr_pg), .RD_ADDR(rd_ea),
        .RD_ADDR_PAGE(rd_apg), .RD_ADDR_VALID(rd_ok), .WR_ADDR(wr_ea),
        .WR_ADDR_PAGE(wr_apg), .WR_ADDR_VALID(wr_ok), .ADDR_ERR_TRAP(trap));
    dpag_mem_model dpag_mem_model_inst (.clock(clock), .rd_ok(rd_ok), .rd_pg(rd_apg),
        .rd_ea(rd_ea), .wr_ok(wr_ok), .wr_pg(wr_apg), .wr_ea(wr_ea), .wr_data(m_wd),
        .rd_data(m_rd));
    // Core clock, 8 ns period
    always #4 clock = ~clock;
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            if (n_errors == 0 && checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // Page loads take one cycle ahead of the access
    task load(input [9:0] rp, input [9:0] wp);
        begin
            @(negedge clock);
            rd_we = 1'b1;
            wr_we = 1'b1;
            rd_wd = rp;
            wr_wd = wp;
            @(negedge clock);
            rd_we = 1'b0;
            wr_we = 1'b0;
        end
    endtask
    task acc(input r, input w, input [2:0] m, input [15:0] b, input [15:0] o);
        begin
            rd_v = r;
            wr_v = w;
            md = m;
            bs = b;
            ofs = o;
            @(negedge clock);
            rd_v = 1'b0;
            wr_v = 1'b0;
        end
    endtask
    // One access on side s (1 = write); v clear means a trap is due
    task xs(input s, input [9:0] pg, input [2:0] m, input [15:0] b, input [15:0] o,
        input [15:0] ea, input [9:0] np, input v);
        begin
            load(s ? 10'h010 : pg, s ? pg : 10'h010);
            acc(!s, s, m, b, o);
            chk(s ? wr_ok : rd_ok, v);
            chk(trap, !v);
            chk(s ? wr_pg : rd_pg, np);
            if (v) begin
                chk(s ? wr_ea : rd_ea, ea);
                chk(s ? wr_apg : rd_apg, (m == `DPAG_MODE_POSTMOD) ? pg : np);
            end
        end
    endtask
    task t_carry;
        begin
            xs(0, 10'h005, 3'h1, 16'hFFFE, 16'h0002, 16'h8000, 10'h006, 1'h1);
            xs(0, 10'h006, 3'h2, 16'h8000, 16'hFFFE, 16'h8000, 10'h005, 1'h1);
            xs(1, 10'h005, 3'h1, 16'hFFFE, 16'h0002, 16'h8000, 10'h006, 1'h1);
            xs(0, 10'h2FF, 3'h1, 16'hFFFE, 16'h0002, 16'h8000, 10'h300, 1'h1);
            xs(0, 10'h300, 3'h1, 16'h8000, 16'hFFFE, 16'hFFFE, 10'h2FF, 1'h1);
        end
    endtask
    task t_wrap;
        begin
            xs(0, 10'h005, 3'h3, 16'hFFFE, 16'h0002, 16'h8000, 10'h005, 1'h1);
            xs(0, 10'h005, 3'h4, 16'hFFFE, 16'h0002, 16'h8000, 10'h005, 1'h1);
            xs(0, 10'h005, 3'h0, 16'hFFFE, 16'h0002, 16'hFFFE, 10'h005, 1'h1);
            xs(0, 10'h005, 3'h1, 16'h7FFE, 16'h0002, 16'h8000, 10'h005, 1'h1);
            for (i = 0; i < 16; i = i + 1)
                xs(0, 10'h005, `DPAG_MODE_BITREV, 16'h8000 | i[15:0], 16'h0000,
                    {12'h800, i[0], i[1], i[2], i[3]}, 10'h005, 1'h1);
        end
    endtask
    task t_bound;
        begin
            xs(0, 10'h1FF, 3'h1, 16'hFFFE, 16'h0002, 16'h0000, 10'h1FF, 1'h1);
            xs(0, 10'h3FF, 3'h1, 16'hFFFE, 16'h0002, 16'h0000, 10'h3FF, 1'h1);
            xs(0, 10'h001, 3'h1, 16'h8000, 16'hFFFE, 16'h7FFE, 10'h001, 1'h1);
            xs(0, 10'h200, 3'h1, 16'h8000, 16'hFFFE, 16'h7FFE, 10'h200, 1'h1);
            xs(0, 10'h000, 3'h1, 16'h8000, 16'h0002, 16'h0000, 10'h000, 1'h0);
            xs(1, 10'h200, 3'h1, 16'h8000, 16'h0002, 16'h0000, 10'h200, 1'h0);
        end
    endtask
    // Store a word, move it to another page, read it back there
    task t_move;
        begin
            load(10'h005, 10'h005);
            m_wd = 16'hA5C3;
            acc(0, 1, 3'h1, 16'h9000, 16'h0000);
            load(10'h005, 10'h030);
            acc(1, 1, 3'h1, 16'h9000, 16'h0000);
            chk(rd_apg, 10'h005);
            chk(wr_apg, 10'h030);
            load(10'h030, 10'h030);
            acc(1, 0, 3'h1, 16'h9000, 16'h0000);
            @(negedge clock);
            chk(m_rd, 16'hA5C3);
        end
    endtask
    // Mid-run reset puts both page selects back to their reset value
    task t_reset;
        begin
            load(10'h0AB, 10'h0CD);
            chk(rd_pg, 10'h0AB);
            chk(wr_pg, 10'h0CD);
            rst_b = 1'b0;
            @(negedge clock);
            chk(rd_pg, `DPAG_RD_PAGE_RST);
            chk(wr_pg, `DPAG_WR_PAGE_RST);
            chk(trap, 1'b0);
            rst_b = 1'b1;
            @(negedge clock);
        end
    endtask
    // Main sequence
    initial begin
        repeat (4) @(negedge clock);
        rst_b = 1'b1;
        chk(rd_pg, `DPAG_RD_PAGE_RST);
        chk(wr_pg, `DPAG_WR_PAGE_RST);
        t_carry;
        t_wrap;
        t_bound;
        t_move;
        t_reset;
        report_and_stop;
    end
    // Watchdog
    initial begin
        #20000;
        n_errors = n_errors + 1;
        report_and_stop;
    end
endmodule // dpag_top_tb_top
